// ===== core/cctb_if.sv
// Interface joining the processor side translator and the slave device
`timescale 1ns/10ps
interface cctb_if;
  logic       local_addr_strobe_n;
  logic       local_addr_strobe_oe;
  logic       local_data_strobe_n;
  logic       local_data_strobe_oe;
  logic       register_select_n;
  logic       bus_out_select_n;
  logic [2:0] function_code_in;
  logic       size_ack_lo_n;
  logic       size_ack_hi_n;
  logic       local_bus_error_n;
  logic       local_autovector_n;
  logic       local_halt_n;

  modport translator (
    output local_addr_strobe_n, local_addr_strobe_oe,
    output local_data_strobe_n, local_data_strobe_oe,
    output register_select_n, bus_out_select_n, function_code_in,
    input  size_ack_lo_n, size_ack_hi_n, local_bus_error_n,
    input  local_autovector_n, local_halt_n
  );
  modport slave (
    input  local_addr_strobe_n, local_addr_strobe_oe,
    input  local_data_strobe_n, local_data_strobe_oe,
    input  register_select_n, bus_out_select_n, function_code_in,
    output size_ack_lo_n, size_ack_hi_n, local_bus_error_n,
    output local_autovector_n, local_halt_n
  );
endinterface : cctb_if

// ===== core/cctb_pkg.sv
// Package of shared constants and types for the cycle translation bridge
package cctb_pkg;

  // ------------------------------------------------------------
  // Transfer type codes
  // ------------------------------------------------------------
  localparam logic [1:0] TT_NORMAL = 2'h0;
  localparam logic [1:0] TT_BURST  = 2'h1;
  localparam logic [1:0] TT_ALTFC  = 2'h2;
  localparam logic [1:0] TT_ACK    = 2'h3;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic       SIZING_DISABLE_RST = 1'h1;
  localparam logic [1:0] SLAVE_WAIT_CYCLES  = 2'h2;

  // ------------------------------------------------------------
  // Slave termination kinds
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CCTB_TERM_OK   = 3'h0,
    CCTB_TERM_BERR = 3'h1,
    CCTB_TERM_RTRY = 3'h2,
    CCTB_TERM_CPU_AUTOVECTOR = 3'h3
  } cctb_term_type;

endpackage : cctb_pkg

// ===== core/cctb_slave.sv
// Slave end: samples the strobe and answers with termination codes
`timescale 1ns/10ps
module cctb_slave (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  cctb_if.slave            bus,
  input  wire logic        sizing_disable_bit_in,
  input  wire logic        want_16bit_in,
  input  wire logic        want_error_in,
  input  wire logic        want_retry_in,
  input  wire logic        want_autovec_in,
  input  wire logic [31:0] wdata_in,
  output logic             selected_out,
  output logic [31:0]      wdata_out,
  output logic [2:0]       function_code_out
);
  // ------------------------------------------------------------
  // Selection and answer
  // ------------------------------------------------------------
  logic        sel_r, sel_nxt;
  logic [1:0]  wait_r, wait_nxt;
  logic [4:0]  term_r, term_nxt; // ack0 ack1 berr cpu_autovector halt, low active
  logic [31:0] wd_r, wd_nxt;
  logic [2:0]  fc_r, fc_nxt;
  logic        as_low;

  assign as_low = bus.local_addr_strobe_oe & ~bus.local_addr_strobe_n;

  always_comb begin
    sel_nxt  = sel_r;
    wait_nxt = wait_r;
    term_nxt = term_r;
    wd_nxt   = wd_r;
    fc_nxt   = fc_r;
    if (!as_low) begin
      sel_nxt  = 1'b0;
      wait_nxt = 2'h0;
      term_nxt = 5'h1f;
    end else if (!sel_r) begin
      if (!bus.register_select_n || !bus.bus_out_select_n) begin
        sel_nxt  = 1'b1;
        wait_nxt = cctb_pkg::SLAVE_WAIT_CYCLES;
        fc_nxt   = bus.function_code_in;
      end
    end else if (wait_r != 2'h0) begin
      wait_nxt = wait_r - 2'h1;
      if (wait_r == 2'h1) begin
        wd_nxt = wdata_in;
        if (want_retry_in)
          term_nxt = 5'b11010;
        else if (want_error_in)
          term_nxt = 5'b11011;
        else if (want_autovec_in)
          term_nxt = 5'b11101;
        else if (want_16bit_in && !sizing_disable_bit_in)
          term_nxt = 5'b01111;
        else
          term_nxt = 5'b00111;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_r  <= 1'b0;
      wait_r <= 2'h0;
      term_r <= 5'h1f;
      wd_r   <= 32'h0;
      fc_r   <= 3'h0;
    end else begin
      sel_r  <= sel_nxt;
      wait_r <= wait_nxt;
      term_r <= term_nxt;
      wd_r   <= wd_nxt;
      fc_r   <= fc_nxt;
    end
  end

  assign bus.size_ack_lo_n      = term_r[4];
  assign bus.size_ack_hi_n      = term_r[3];
  assign bus.local_bus_error_n  = term_r[2];
  assign bus.local_autovector_n = term_r[1];
  assign bus.local_halt_n       = term_r[0];
  assign selected_out           = sel_r;
  assign wdata_out              = wd_r;
  assign function_code_out      = fc_r;
endmodule : cctb_slave

// ===== core/cctb_translator.sv
// Translator end: maps processor cycles onto the slave handshake
// Function
// - Processor cycle spans two bus clocks minimum
// - Processor termination codes ack, error, retry, autovector
// - Processor waits while no termination sampled
// - Slave selected by strobe plus select
// - Slave answers with active low codes
// - Master waits while slave gives nothing
// - Terminations double sampled on rising edges
// - Write data valid by first sample
// - Machine clocked at twice bus clock
// - Idle until start, then assert strobes
// - No termination: step M1, M3, M1
// - Termination seen: go M2 then M4
// - Still held after M4: enter M5, acknowledge
// - Address strobe held through M5
// - M6 drives strobes, selects and processor codes high
// - Sizing disabled forces 32-bit acknowledge
// - Only size acknowledge low watched
// - Transfer type gates selects and acknowledge
// - Burst moves end with bus error
// - Transfer modifier drives function code directly
// - Alternate code may redefine address map
`timescale 1ns/10ps
module cctb_translator (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  cctb_if.translator      bus,
  input  wire logic       cpu_transfer_start_n_in,
  input  wire logic       transfer_type_hi_in,
  input  wire logic       transfer_type_lo_in,
  input  wire logic [2:0] transfer_modifier_in,
  input  wire logic       reg_hit_in,
  input  wire logic       altfc_is_bus_in,
  output logic            cpu_transfer_ack_n_out,
  output logic            cpu_transfer_ack_oe_out,
  output logic            cpu_transfer_error_n_out,
  output logic            cpu_transfer_error_oe_out,
  output logic            cpu_autovector_n_out,
  output logic            cpu_autovector_oe_out,
  output logic            interrupt_ack_n_out,
  output logic            local_bus_clock_out
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_M0 = 8'h01, ST_M1 = 8'h02, ST_M2 = 8'h04, ST_M3 = 8'h08,
    ST_M4 = 8'h10, ST_M5 = 8'h20, ST_M6 = 8'h40, ST_BE = 8'h80
  } cctb_state_type;

  cctb_state_type st_r, st_nxt;
  logic       ph_r, ph_nxt;       // Bus clock phase, 1 = high half
  logic [2:0] cpu_r, cpu_nxt;     // ack, err, cpu_autovector (low active)
  logic       cpu_oe_r, cpu_oe_nxt;
  logic       as_r, as_nxt, ds_r, ds_nxt, soe_r, soe_nxt;
  logic       rs_r, rs_nxt, bo_r, bo_nxt, iack_r, iack_nxt;
  logic [2:0] fc_r, fc_nxt;
  logic [1:0] tt;
  logic       term_seen, fall_edge;

  assign tt        = {transfer_type_hi_in, transfer_type_lo_in};
  assign fall_edge = ph_r;
  assign term_seen = !bus.size_ack_lo_n || !bus.local_bus_error_n ||
                     !bus.local_autovector_n;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    ph_nxt     = ~ph_r;
    cpu_nxt    = cpu_r;
    cpu_oe_nxt = cpu_oe_r;
    as_nxt     = as_r;
    ds_nxt     = ds_r;
    soe_nxt    = soe_r;
    rs_nxt     = rs_r;
    bo_nxt     = bo_r;
    iack_nxt   = iack_r;
    fc_nxt     = fc_r;
    case (st_r)
      ST_M0: begin
        soe_nxt    = 1'b0;
        cpu_oe_nxt = 1'b0;
        if (!cpu_transfer_start_n_in && fall_edge) begin
          fc_nxt   = transfer_modifier_in;
          iack_nxt = !(tt == cctb_pkg::TT_ACK);
          if (tt == cctb_pkg::TT_BURST) begin
            st_nxt = ST_BE;
          end else begin
            rs_nxt  = !((tt == cctb_pkg::TT_NORMAL) && reg_hit_in);
            bo_nxt  = !(((tt == cctb_pkg::TT_NORMAL) && !reg_hit_in) ||
                       ((tt == cctb_pkg::TT_ALTFC) && altfc_is_bus_in));
            as_nxt  = 1'b0;
            ds_nxt  = 1'b0;
            soe_nxt = 1'b1;
            st_nxt  = ST_M1;
          end
        end
      end
      ST_M1: st_nxt = term_seen ? ST_M2 : ST_M3;
      ST_M3: st_nxt = ST_M1;
      ST_M2: st_nxt = ST_M4;
      ST_M4: begin
        if (!term_seen) begin
          st_nxt = ST_M1;
        end else begin
          st_nxt     = ST_M5;
          cpu_oe_nxt = 1'b1;
          ds_nxt     = 1'b1;
          if (!bus.local_bus_error_n && !bus.local_halt_n)
            cpu_nxt = 3'b001;
          else if (!bus.local_bus_error_n)
            cpu_nxt = 3'b101;
          else if (!bus.local_autovector_n)
            cpu_nxt = 3'b010;
          else
            cpu_nxt = 3'b011;
        end
      end
      ST_M5: begin
        st_nxt  = ST_M6;
        cpu_nxt = 3'b111;
        as_nxt  = 1'b1;
        ds_nxt  = 1'b1;
        rs_nxt  = 1'b1;
        bo_nxt  = 1'b1;
        iack_nxt = 1'b1;
      end
      ST_M6: begin
        st_nxt     = ST_M0;
        soe_nxt    = 1'b0;
        cpu_oe_nxt = 1'b0;
      end
      ST_BE: begin
        if (!cpu_oe_r) begin
          cpu_oe_nxt = 1'b1;
          cpu_nxt    = 3'b101;
        end else begin
          cpu_nxt = 3'b111;
          st_nxt  = ST_M6;
        end
      end
      default: st_nxt = ST_M0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r     <= ST_M0;
      ph_r     <= 1'b0;
      cpu_r    <= 3'h7;
      cpu_oe_r <= 1'b0;
      as_r     <= 1'b1;
      ds_r     <= 1'b1;
      soe_r    <= 1'b0;
      rs_r     <= 1'b1;
      bo_r     <= 1'b1;
      iack_r   <= 1'b1;
      fc_r     <= 3'h0;
    end else begin
      st_r     <= st_nxt;
      ph_r     <= ph_nxt;
      cpu_r    <= cpu_nxt;
      cpu_oe_r <= cpu_oe_nxt;
      as_r     <= as_nxt;
      ds_r     <= ds_nxt;
      soe_r    <= soe_nxt;
      rs_r     <= rs_nxt;
      bo_r     <= bo_nxt;
      iack_r   <= iack_nxt;
      fc_r     <= fc_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.local_addr_strobe_n   = as_r;
  assign bus.local_addr_strobe_oe  = soe_r;
  assign bus.local_data_strobe_n   = ds_r;
  assign bus.local_data_strobe_oe  = soe_r;
  assign bus.register_select_n     = rs_r;
  assign bus.bus_out_select_n      = bo_r;
  assign bus.function_code_in      = fc_r;
  assign cpu_transfer_ack_n_out    = cpu_r[2];
  assign cpu_transfer_error_n_out  = cpu_r[1];
  assign cpu_autovector_n_out      = cpu_r[0];
  assign cpu_transfer_ack_oe_out   = cpu_oe_r;
  assign cpu_transfer_error_oe_out = cpu_oe_r;
  assign cpu_autovector_oe_out     = cpu_oe_r;
  assign interrupt_ack_n_out       = iack_r;
  assign local_bus_clock_out       = ph_r;
endmodule : cctb_translator

// ===== tb/cctb_props.sv
// Checker of the strobe and termination handshake between the two ends
`timescale 1ns/10ps
module cctb_props (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       local_addr_strobe_n,
  input wire logic       local_addr_strobe_oe,
  input wire logic       local_data_strobe_n,
  input wire logic [2:0] function_code_in,
  input wire logic       size_ack_lo_n,
  input wire logic       size_ack_hi_n,
  input wire logic       local_bus_error_n,
  input wire logic       local_autovector_n,
  input wire logic       local_halt_n
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire any_term = !size_ack_lo_n || !local_bus_error_n || !local_autovector_n;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  strobe_release_a: assert property (
    !local_addr_strobe_oe |-> local_addr_strobe_n)
    else $error("address strobe low while released");
  strobes_together_a: assert property (
    $fell(local_addr_strobe_n) |-> !local_data_strobe_n)
    else $error("data strobe late");
  min_cycle_a: assert property (
    $fell(local_addr_strobe_n) |-> !local_addr_strobe_n [*4])
    else $error("strobe cycle too short");
  high_then_float_a: assert property (
    $rose(local_addr_strobe_n) |-> local_addr_strobe_oe ##1
    !local_addr_strobe_oe)
    else $error("strobe not driven high before float");
  double_sample_a: assert property (
    $rose(local_addr_strobe_n) |-> $past(any_term, 2))
    else $error("cycle ended without held termination");
  term_after_strobe_a: assert property (
    $rose(any_term) |-> $past(!local_addr_strobe_n, 2))
    else $error("termination without strobe");
  size_pair_a: assert property (
    !size_ack_hi_n |-> !size_ack_lo_n)
    else $error("upper size acknowledge alone");
  retry_code_a: assert property (
    !local_halt_n |-> !local_bus_error_n && size_ack_lo_n)
    else $error("halt without bus error");
  code_stable_a: assert property (
    !local_addr_strobe_n && $past(!local_addr_strobe_n) |->
    $stable(function_code_in))
    else $error("function code moved in cycle");
  ok_c: cover property ($fell(size_ack_lo_n));
  retry_c: cover property ($fell(local_halt_n));
  cpu_autovector_c: cover property ($fell(local_autovector_n));
endmodule : cctb_props

// ===== tb/tb.sv
// Self-checking bench joining the translator and slave ends
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [1:0] tt;
    logic [2:0] tm;
    logic       rh;
    logic       sz;
    logic [3:0] want;
    logic [2:0] exp;
  } cctb_row_type;
  logic         mclk_in = 1'h0;
  logic         rst_n_in = 1'h0;
  logic         start_n = 1'h1;
  logic [1:0]   tt = 2'h0;
  logic [2:0]   tm = 3'h0;
  logic         reg_hit = 1'h0;
  logic         sizing = 1'h1;
  logic [3:0]   want = 4'h0;
  logic [31:0]  wdata = 32'h0;
  logic         ack_n, ack_oe, err_n, err_oe, av_n, av_oe, iack_n, bclk, b;
  logic [31:0]  wdata_o;
  logic [2:0]   fc_o;
  int           n_errors = 0;
  int           num_checks = 0;
  // Rows: type, modifier, reg hit or alt to bus, sizing off, answer, code
  cctb_row_type rows [9] = '{
    '{2'h0, 3'h1, 1'h1, 1'h1, 4'h0, 3'h3}, '{2'h0, 3'h5, 1'h0, 1'h1, 4'h4, 3'h5},
    '{2'h0, 3'h2, 1'h0, 1'h1, 4'h2, 3'h1}, '{2'h0, 3'h6, 1'h0, 1'h1, 4'h1, 3'h2},
    '{2'h0, 3'h7, 1'h1, 1'h1, 4'h8, 3'h3}, '{2'h0, 3'h3, 1'h0, 1'h0, 4'h8, 3'h3},
    '{2'h0, 3'h4, 1'h0, 1'h1, 4'h6, 3'h1}, '{2'h1, 3'h0, 1'h0, 1'h1, 4'h0, 3'h5},
    '{2'h2, 3'h5, 1'h1, 1'h1, 4'h0, 3'h3}};
  cctb_if bus ();
  cctb_translator i_cctb_translator (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus(bus.translator),
    .cpu_transfer_start_n_in(start_n), .transfer_type_hi_in(tt[1]),
    .transfer_type_lo_in(tt[0]), .transfer_modifier_in(tm),
    .reg_hit_in(reg_hit), .altfc_is_bus_in(reg_hit),
    .cpu_transfer_ack_n_out(ack_n), .cpu_transfer_ack_oe_out(ack_oe),
    .cpu_transfer_error_n_out(err_n), .cpu_transfer_error_oe_out(err_oe),
    .cpu_autovector_n_out(av_n), .cpu_autovector_oe_out(av_oe),
    .interrupt_ack_n_out(iack_n), .local_bus_clock_out(bclk));
  cctb_slave i_cctb_slave (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus(bus.slave),
    .sizing_disable_bit_in(sizing), .want_16bit_in(want[3]),
    .want_error_in(want[2]), .want_retry_in(want[1]),
    .want_autovec_in(want[0]), .wdata_in(wdata), .selected_out(),
    .wdata_out(wdata_o), .function_code_out(fc_o));
  cctb_props i_cctb_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .local_addr_strobe_n(bus.local_addr_strobe_n),
    .local_addr_strobe_oe(bus.local_addr_strobe_oe),
    .local_data_strobe_n(bus.local_data_strobe_n),
    .function_code_in(bus.function_code_in),
    .size_ack_lo_n(bus.size_ack_lo_n), .size_ack_hi_n(bus.size_ack_hi_n),
    .local_bus_error_n(bus.local_bus_error_n),
    .local_autovector_n(bus.local_autovector_n),
    .local_halt_n(bus.local_halt_n));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic launch;
    int k;
    k = 0;
    while (bclk !== 1'h1 && k < 4) begin
      @(negedge mclk_in);
      k++;
    end
    start_n = 1'h0;
    @(negedge mclk_in);
    start_n = 1'h1;
  endtask : launch
  task automatic xfer(input cctb_row_type r);
    int k;
    launch();
    k = 0;
    while (!(ack_oe === 1'h1 || err_oe === 1'h1 || av_oe === 1'h1) &&
           k < 200) begin
      @(negedge mclk_in);
      k++;
    end
    chk({ack_n, err_n, av_n}, r.exp);
    @(negedge mclk_in);
    chk({ack_n, err_n, av_n, ack_oe}, 4'hf);
    @(negedge mclk_in);
    chk({ack_oe, err_oe, av_oe}, 3'h0);
  endtask : xfer
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial forever #12.5 mclk_in = ~mclk_in;
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1'h1;
    @(negedge mclk_in);
    chk({bus.local_addr_strobe_n, bus.local_addr_strobe_oe, ack_oe},
        3'h4);
    chk({bus.register_select_n, bus.bus_out_select_n}, 2'h3);
    for (int i = 0; i < 9; i++) begin
      {tt, tm, reg_hit, sizing, want} = rows[i][13:3];
      wdata = {16'hc3a5, 13'h0, tm};
      xfer(rows[i]);
      if (rows[i].tt != 2'h1) chk(fc_o, rows[i].tm);
      if (rows[i].rh) chk(wdata_o, wdata);
    end
    tt = 2'h0;
    want = 4'h0;
    repeat (8) @(negedge mclk_in);
    chk({bus.local_addr_strobe_n, ack_oe}, 2'h2);
    b = bclk;
    @(negedge mclk_in);
    chk(bclk, !b);
    tt = 2'h3;
    launch();
    @(negedge mclk_in);
    chk(iack_n, 1'h0);
    chk({bus.register_select_n, bus.bus_out_select_n}, 2'h3);
    rst_n_in = 1'h0;
    @(negedge mclk_in);
    chk({bus.local_addr_strobe_n, bus.local_addr_strobe_oe, ack_oe},
        3'h4);
    chk(iack_n, 1'h1);
    tt = 2'h0;
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1'h1;
    @(negedge mclk_in);
    xfer(rows[0]);
    end_of_test();
  end
endmodule : tb
